// File: verilog/qfc_host.sv
/*
  Host controller driving a serial NOR flash in four-line command mode.
  Assumes the bench resolves the four data wires from o_io_oe and that the
  flash launches read nibbles on the falling edge of o_sclk.
*/
//
// Contract
// - 06h sets write-permit latch, no trailing bytes
// - 04h clears write-permit latch, no trailing bytes
// - 50h arms next status write volatile
// - 36h/39h lock/unlock, 3Ch/3Dh read lock, 3 address
// - 7Eh locks every block
// - 98h unlocks every block
// - 01h/31h write one status byte
// - 11h writes one configuration byte
// - 81h/20h/52h erase page/sector/block, 3 address
// - D8h erases 64K block; 60h/C7h whole array
// - B9h enters deep power-down
// - ABh 3 address, one signature, leaves power-down
// - C0h byte sets read dummy and wrap; the host's dummy phase stays Q_DMY_NIB (2 nibbles) whatever the byte holds
// - 0Bh address, dummy, stream until deselect
// - 0Ch address, dummy, wrapped burst stream
// - EBh address, dummy, stream on four lines
// - FFh leaves four-line mode
// - Two nibbles per byte, high nibble first
`timescale 1ns/1ps
`include "qfc_map.svh"
module qfc_host #(
  parameter int HALF = 4,
  parameter int GAP = `Q_CS_GAP_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_cmd_valid,
  input wire qfc_pkg::qfc_cmd_t i_cmd,
  output logic o_cmd_ready,
  output logic o_cmd_err,
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_data,
  output logic o_wr_ready,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  output logic o_busy,
  input wire logic i_qpi_resume,
  output logic o_wpl,
  output logic o_vol_armed,
  output logic o_deep_pd,
  output logic o_suspended,
  output logic o_qpi_active,
  output logic [7:0] o_read_param,
  output logic o_cs_n,
  output logic o_sclk,
  input wire logic [3:0] i_io_in,
  output logic [3:0] o_io_out,
  output logic [3:0] o_io_oe
);
  localparam logic [7:0] PH_LAST = 8'(2 * HALF - 1);
  localparam logic [7:0] PH_HALF = 8'(HALF);
  localparam logic [7:0] GAP_LAST = 8'(GAP - 1);

  function automatic qfc_pkg::qfc_fmt_t fmt_of(input logic [7:0] op);
    qfc_pkg::qfc_fmt_t f;
    f = '0;
    f.dir = qfc_pkg::DIR_NONE;
    case (op)
      `Q_WPL_SET, `Q_WPL_CLR, `Q_VOL_ARM, `Q_GLB_LOCK, `Q_GLB_UNLOCK,
      `Q_CHIP_ERASE_A, `Q_CHIP_ERASE_B, `Q_SUSP_A, `Q_SUSP_B, `Q_RESUME_A,
      `Q_RESUME_B, `Q_DPD, `Q_RST_EN, `Q_RST, `Q_QPI_EXIT: begin
        f.ok = 1'b1;
      end
      `Q_LOCK, `Q_UNLOCK, `Q_PG_ERASE, `Q_SEC_ERASE, `Q_B32_ERASE,
      `Q_B64_ERASE: begin
        f.ok = 1'b1;
        f.addr = 1'b1;
      end
      `Q_LOCK_RD_A, `Q_LOCK_RD_B, `Q_SIG_RD: begin
        f = '{ok: 1'b1, addr: 1'b1, dmy: 1'b0, dir: qfc_pkg::DIR_RD, one: 1'b1, max3: 1'b0};
      end
      `Q_SR_LO_RD, `Q_SR_HI_RD, `Q_CFG_RD: begin
        f = '{ok: 1'b1, addr: 1'b0, dmy: 1'b0, dir: qfc_pkg::DIR_RD, one: 1'b1, max3: 1'b0};
      end
      `Q_SR_LO_WR, `Q_SR_HI_WR, `Q_CFG_WR, `Q_RD_PARAM: begin
        f = '{ok: 1'b1, addr: 1'b0, dmy: 1'b0, dir: qfc_pkg::DIR_WR, one: 1'b1, max3: 1'b0};
      end
      `Q_FAST_RD, `Q_WRAP_RD, `Q_QIO_RD: begin
        f = '{ok: 1'b1, addr: 1'b1, dmy: 1'b1, dir: qfc_pkg::DIR_RD, one: 1'b0, max3: 1'b0};
      end
      `Q_ID_RD: begin
        f = '{ok: 1'b1, addr: 1'b1, dmy: 1'b0, dir: qfc_pkg::DIR_RD, one: 1'b0, max3: 1'b0};
      end
      `Q_JEDEC_RD: begin
        f = '{ok: 1'b1, addr: 1'b0, dmy: 1'b0, dir: qfc_pkg::DIR_RD, one: 1'b0, max3: 1'b1};
      end
      `Q_PROG: begin
        f = '{ok: 1'b1, addr: 1'b1, dmy: 1'b0, dir: qfc_pkg::DIR_WR, one: 1'b0, max3: 1'b0};
      end
      default: f = '0;
    endcase
    return f;
  endfunction

  qfc_pkg::qfc_state_t state_r;
  qfc_pkg::qfc_fmt_t fmt_r;
  logic [7:0] op_r, last_op_r, ph_r, ph_nxt, gap_r, rd_data_r, param_r;
  logic [31:0] sh_r;
  logic [3:0] nib_r, io_out_r, oe_r, wlo_r, rd_hi_r, io_s1_r, io_s2_r;
  logic [15:0] cnt_r;
  logic half_r, cs_n_r, sclk_r, rd_valid_r, err_r;
  logic wpl_r, vol_r, dpd_r, susp_r, qpi_r;

  wire qfc_pkg::qfc_fmt_t fmt_in = fmt_of(i_cmd.opcode);
  wire idle = state_r == qfc_pkg::S_IDLE;
  wire take = i_cmd_valid && idle;
  wire bad_rst = i_cmd.opcode == `Q_RST && last_op_r != `Q_RST_EN;
  wire bad_dpd = dpd_r && i_cmd.opcode != `Q_SIG_RD;
  wire bad = !fmt_in.ok || !qpi_r || bad_rst || bad_dpd;
  wire start = take && !bad;
  wire [15:0] len1 = (i_cmd.len == 16'h0000) ? 16'h0001 : i_cmd.len;
  wire [15:0] len3 = (len1 > `Q_JEDEC_MAX) ? `Q_JEDEC_MAX : len1;
  wire [15:0] n_bytes = (fmt_in.dir == qfc_pkg::DIR_NONE) ? 16'h0000 :
                        fmt_in.one ? 16'h0001 : fmt_in.max3 ? len3 : len1;
  wire run = state_r == qfc_pkg::S_SHIFT || state_r == qfc_pkg::S_DMY ||
             state_r == qfc_pkg::S_WDATA || state_r == qfc_pkg::S_RDATA;
  wire tick = run && ph_r == PH_LAST;
  wire fx = state_r == qfc_pkg::S_GAP && gap_r == 8'h00;
  wire wtake = state_r == qfc_pkg::S_WSTALL && i_wr_valid;
  // Ops that finish a write cycle and drop the latch
  wire wpl_drop = op_r == `Q_WPL_CLR || op_r == `Q_SR_LO_WR || op_r == `Q_SR_HI_WR ||
                  op_r == `Q_CFG_WR || op_r == `Q_PROG || op_r == `Q_PG_ERASE ||
                  op_r == `Q_SEC_ERASE || op_r == `Q_B32_ERASE || op_r == `Q_B64_ERASE ||
                  op_r == `Q_CHIP_ERASE_A || op_r == `Q_CHIP_ERASE_B || op_r == `Q_RST;

  assign ph_nxt = !run ? 8'h00 : tick ? 8'h00 : ph_r + 8'h01;
  assign o_cmd_ready = idle;
  assign o_wr_ready = state_r == qfc_pkg::S_WSTALL;
  assign o_busy = !idle;
  assign o_cmd_err = err_r;
  assign o_rd_valid = rd_valid_r;
  assign o_rd_data = rd_data_r;
  assign o_wpl = wpl_r;
  assign o_vol_armed = vol_r;
  assign o_deep_pd = dpd_r;
  assign o_suspended = susp_r;
  assign o_qpi_active = qpi_r;
  assign o_read_param = param_r;
  assign o_cs_n = cs_n_r;
  assign o_sclk = sclk_r;
  assign o_io_out = io_out_r;
  assign o_io_oe = oe_r;

  // Pin synchroniser
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
    end else begin
      io_s1_r <= i_io_in;
      io_s2_r <= io_s1_r;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_r <= 8'h00;
      sclk_r <= 1'b0;
      gap_r <= 8'h00;
      err_r <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
      sclk_r <= run && ph_nxt >= PH_HALF;
      gap_r <= (state_r == qfc_pkg::S_GAP) ? gap_r + 8'h01 : 8'h00;
      err_r <= take && bad;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= qfc_pkg::S_IDLE;
      fmt_r <= '0;
      op_r <= 8'h00;
      sh_r <= 32'h0000_0000;
      nib_r <= 4'h0;
      cnt_r <= 16'h0000;
      half_r <= 1'b0;
      cs_n_r <= 1'b1;
      io_out_r <= 4'h0;
      oe_r <= 4'h0;
      wlo_r <= 4'h0;
      rd_hi_r <= 4'h0;
    end else begin
      case (state_r)
        qfc_pkg::S_IDLE: if (start) begin
          state_r <= qfc_pkg::S_SHIFT;
          fmt_r <= fmt_in;
          op_r <= i_cmd.opcode;
          sh_r <= {i_cmd.opcode, i_cmd.addr};
          nib_r <= fmt_in.addr ? `Q_ADDR_NIB : `Q_OP_NIB;
          cnt_r <= n_bytes;
          cs_n_r <= 1'b0;
          oe_r <= 4'hF;
          io_out_r <= i_cmd.opcode[7:4];
        end
        qfc_pkg::S_SHIFT: if (tick) begin
          if (nib_r != 4'h1) begin
            sh_r <= {sh_r[27:0], 4'h0};
            io_out_r <= sh_r[27:24];
            nib_r <= nib_r - 4'h1;
          end else if (fmt_r.dmy) begin
            state_r <= qfc_pkg::S_DMY;
            nib_r <= `Q_DMY_NIB;
            oe_r <= 4'h0;
          end else if (fmt_r.dir == qfc_pkg::DIR_WR) begin
            state_r <= qfc_pkg::S_WSTALL;
          end else if (fmt_r.dir == qfc_pkg::DIR_RD) begin
            state_r <= qfc_pkg::S_RDATA;
            oe_r <= 4'h0;
            half_r <= 1'b0;
          end else begin
            state_r <= qfc_pkg::S_GAP;
            cs_n_r <= 1'b1;
            oe_r <= 4'h0;
          end
        end
        qfc_pkg::S_DMY: if (tick) begin
          if (nib_r != 4'h1) begin
            nib_r <= nib_r - 4'h1;
          end else begin
            state_r <= qfc_pkg::S_RDATA;
            half_r <= 1'b0;
          end
        end
        // write byte waits with clock low
        qfc_pkg::S_WSTALL: if (i_wr_valid) begin
          io_out_r <= i_wr_data[7:4];
          wlo_r <= i_wr_data[3:0];
          half_r <= 1'b0;
          state_r <= qfc_pkg::S_WDATA;
        end
        qfc_pkg::S_WDATA: if (tick) begin
          if (!half_r) begin
            io_out_r <= wlo_r;
            half_r <= 1'b1;
          end else if (cnt_r == 16'h0001) begin
            state_r <= qfc_pkg::S_GAP;
            cs_n_r <= 1'b1;
            oe_r <= 4'h0;
          end else begin
            cnt_r <= cnt_r - 16'h0001;
            state_r <= qfc_pkg::S_WSTALL;
          end
        end
        qfc_pkg::S_RDATA: if (tick) begin
          if (!half_r) begin
            rd_hi_r <= io_s2_r;
            half_r <= 1'b1;
          end else begin
            half_r <= 1'b0;
            if (cnt_r == 16'h0001) begin
              state_r <= qfc_pkg::S_GAP;
              cs_n_r <= 1'b1;
            end else begin
              cnt_r <= cnt_r - 16'h0001;
            end
          end
        end
        qfc_pkg::S_GAP: if (gap_r == GAP_LAST) begin
          state_r <= qfc_pkg::S_IDLE;
        end
        default: state_r <= qfc_pkg::S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else begin
      rd_valid_r <= state_r == qfc_pkg::S_RDATA && tick && half_r;
      if (state_r == qfc_pkg::S_RDATA && tick && half_r) begin
        rd_data_r <= {rd_hi_r, io_s2_r};
      end
    end
  end

  // Shadows of device state, updated one cycle after cs rises; read param when its byte is taken, four-line mode also on i_qpi_resume
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wpl_r <= 1'b0;
      vol_r <= 1'b0;
      dpd_r <= 1'b0;
      susp_r <= 1'b0;
      qpi_r <= 1'b1;
      last_op_r <= 8'h00;
      param_r <= 8'h00;
    end else begin
      if (wtake && op_r == `Q_RD_PARAM) begin
        param_r <= i_wr_data;
      end
      if (fx) begin
        last_op_r <= op_r;
        if (op_r == `Q_WPL_SET) begin
          wpl_r <= 1'b1;
        end else if (wpl_drop) begin
          wpl_r <= 1'b0;
        end
        vol_r <= op_r == `Q_VOL_ARM;
        if (op_r == `Q_DPD) begin
          dpd_r <= 1'b1;
        end else if (op_r == `Q_SIG_RD || op_r == `Q_RST) begin
          dpd_r <= 1'b0;
        end
        if (op_r == `Q_SUSP_A || op_r == `Q_SUSP_B) begin
          susp_r <= 1'b1;
        end else if (op_r == `Q_RESUME_A || op_r == `Q_RESUME_B || op_r == `Q_RST) begin
          susp_r <= 1'b0;
        end
      end
      if (fx && op_r == `Q_QPI_EXIT) begin
        qpi_r <= 1'b0;
      end else if (i_qpi_resume) begin
        qpi_r <= 1'b1;
      end
    end
  end

  a_wpl_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    fx && op_r == `Q_WPL_SET |=> o_wpl) else $error("latch not set");
  a_wpl_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    fx && op_r == `Q_WPL_CLR |=> !o_wpl) else $error("latch not cleared");
  a_vol_arm: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    fx && op_r == `Q_VOL_ARM |=> o_vol_armed) else $error("volatile arm lost");
  a_dpd_enter: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    fx && op_r == `Q_DPD |=> o_deep_pd) else $error("power-down not tracked");
  a_dpd_exit: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    fx && op_r == `Q_SIG_RD |=> !o_deep_pd) else $error("power-down not left");
  a_rst_pair: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    take && i_cmd.opcode == `Q_RST && last_op_r != `Q_RST_EN |=> o_cmd_err && o_cs_n)
    else $error("unpaired reset sent");
  a_qpi_exit: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    fx && op_r == `Q_QPI_EXIT && !i_qpi_resume |=> !o_qpi_active) else $error("mode kept");
  a_read_release: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    state_r == qfc_pkg::S_RDATA || state_r == qfc_pkg::S_DMY |-> o_io_oe == 4'h0)
    else $error("lines driven during read");
  a_jedec_cap: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    state_r == qfc_pkg::S_RDATA && op_r == `Q_JEDEC_RD |-> cnt_r <= `Q_JEDEC_MAX)
    else $error("identification read too long");
  a_opcode_first: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $fell(o_cs_n) |-> o_io_out == op_r[7:4] && o_io_oe == 4'hF && !o_sclk)
    else $error("opcode nibble order");
  a_write_high: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    wtake |=> {o_io_out, 4'h0} == ($past(i_wr_data) & 8'hF0) && !o_sclk)
    else $error("write nibble order");
endmodule // qfc_host

// File: pkg/qfc_map.svh
/*
  Opcodes, frame layout and timing counts for the four-line flash host.
  Assumes a 200 MHz core clock; included by bare name.
*/
`ifndef QFC_MAP_SVH
`define QFC_MAP_SVH
`define Q_WPL_SET 8'h06
`define Q_WPL_CLR 8'h04
`define Q_VOL_ARM 8'h50
`define Q_LOCK 8'h36
`define Q_UNLOCK 8'h39
`define Q_LOCK_RD_A 8'h3C
`define Q_LOCK_RD_B 8'h3D
`define Q_GLB_LOCK 8'h7E
`define Q_GLB_UNLOCK 8'h98
`define Q_SR_LO_RD 8'h05
`define Q_SR_HI_RD 8'h35
`define Q_CFG_RD 8'h15
`define Q_SR_LO_WR 8'h01
`define Q_SR_HI_WR 8'h31
`define Q_CFG_WR 8'h11
`define Q_PROG 8'h02
`define Q_PG_ERASE 8'h81
`define Q_SEC_ERASE 8'h20
`define Q_B32_ERASE 8'h52
`define Q_B64_ERASE 8'hD8
`define Q_CHIP_ERASE_A 8'h60
`define Q_CHIP_ERASE_B 8'hC7
`define Q_SUSP_A 8'h75
`define Q_SUSP_B 8'hB0
`define Q_RESUME_A 8'h7A
`define Q_RESUME_B 8'h30
`define Q_DPD 8'hB9
`define Q_SIG_RD 8'hAB
`define Q_RD_PARAM 8'hC0
`define Q_FAST_RD 8'h0B
`define Q_WRAP_RD 8'h0C
`define Q_QIO_RD 8'hEB
`define Q_ID_RD 8'h90
`define Q_JEDEC_RD 8'h9F
`define Q_QPI_EXIT 8'hFF
`define Q_RST_EN 8'h66
`define Q_RST 8'h99
`define Q_OP_NIB 4'h2
`define Q_ADDR_NIB 4'h8
`define Q_DMY_NIB 4'h2
`define Q_JEDEC_MAX 16'h0003
`define Q_CLK_PS 5000
`define Q_CS_GAP_NS 30
`define Q_CS_GAP_CYC ((`Q_CS_GAP_NS * 1000 + `Q_CLK_PS - 1) / `Q_CLK_PS)
`endif

// File: pkg/qfc_pkg.sv
/*
  Types of the four-line flash host: states, command carrier, opcode format.
  Assumes nothing of its surroundings.
*/
package qfc_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_SHIFT, S_DMY, S_WSTALL, S_WDATA, S_RDATA, S_GAP
  } qfc_state_t;
  typedef enum logic [1:0] {DIR_NONE, DIR_WR, DIR_RD} qfc_dir_t;
  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [15:0] len;
  } qfc_cmd_t;
  typedef struct packed {
    logic ok;
    logic addr;
    logic dmy;
    qfc_dir_t dir;
    logic one;
    logic max3;
  } qfc_fmt_t;
endpackage

// File: test/qfc_flash_model.sv
/*
  Behavioural flash device on the four-line link: decodes frames, answers reads.
  Assumes the host launches nibbles on sclk fall and the flash samples on sclk rise.
*/
`timescale 1ns/1ps
module qfc_flash_model #(
  parameter logic [7:0] MAKER = 8'h5a, // Arbitrary value
  parameter logic [15:0] PART = 16'hc317 // Arbitrary value
) (
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic [3:0] i_io,
  output logic [3:0] o_io,
  output logic o_oe
);
  logic [7:0] op = 8'h00, st_lo = 8'h00, st_hi = 8'h00, cfg = 8'h00, b;
  logic [23:0] addr = '0;
  logic [63:0] sh = '0, fr_sh = '0;
  logic wpl = 1'b0, dpd = 1'b0, arm = 1'b0, lk = 1'b0;
  int nib = 0, fr_nib = 0, k;
  // Released lines start from a known level
  initial begin
    o_io = 4'h0;
    o_oe = 1'b0;
  end
  function automatic int hdr(input logic [7:0] c);
    case (c)
      8'h0b, 8'h0c, 8'heb: return 10;
      8'h36, 8'h39, 8'h3c, 8'h3d, 8'h81, 8'h20, 8'h52, 8'hd8, 8'hab, 8'h90, 8'h02: return 8;
      default: return 2;
    endcase
  endfunction
  function automatic logic [7:0] rbyte(input int i);
    case (op)
      8'h05: return {st_lo[7:2], wpl, 1'b0};
      8'h3c, 8'h3d: return {7'h00, lk};
      8'h35: return st_hi;
      8'h15: return cfg;
      8'h9f: return (i == 0) ? MAKER : (i == 1) ? PART[15:8] : PART[7:0];
      8'h90: return i[0] ? PART[7:0] : MAKER;
      8'hab: return PART[7:0];
      8'h0b, 8'h0c, 8'heb: return addr[7:0] + i[7:0];
      default: return 8'h00;
    endcase
  endfunction
  always @(posedge i_sclk) begin
    if (!i_cs_n) begin
      sh = {sh[59:0], i_io};
      nib++;
      if (nib == 2) op = sh[7:0];
      if (nib == 8) addr = sh[23:0];
    end
  end
  always @(negedge i_sclk) begin
    if (!i_cs_n && nib >= 2 && nib >= hdr(op) && (!dpd || op == 8'hab) &&
        (op inside {8'h05, 8'h35, 8'h15, 8'h3c, 8'h3d, 8'hab, 8'h0b, 8'h0c, 8'heb, 8'h90, 8'h9f})) begin
      k = nib - hdr(op);
      b = rbyte(k / 2);
      o_oe = 1'b1;
      o_io = k[0] ? b[3:0] : b[7:4];
    end
  end
  always @(posedge i_cs_n) begin
    o_oe = 1'b0;
    fr_nib = nib;
    fr_sh = sh;
    nib = 0;
    if (fr_nib >= 2 && !(dpd && op != 8'hab)) begin
      case (op)
        8'h06: wpl = 1'b1;
        8'h04, 8'h81, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h02: wpl = 1'b0;
        8'h36, 8'h7e: lk = 1'b1;
        8'h39, 8'h98: lk = 1'b0;
        8'h01: st_lo = sh[7:0];
        8'h31: st_hi = sh[7:0];
        8'h11: cfg = sh[7:0];
        8'hb9: dpd = 1'b1;
        8'hab: dpd = 1'b0;
        8'h99: if (arm) wpl = 1'b0;
        default: ;
      endcase
      if (op == 8'h01) wpl = 1'b0;
      arm = (op == 8'h66);
    end
  end
endmodule // qfc_flash_model

// File: test/tb_qfc_host.sv
/*
  Self-checking bench for the four-line flash host.
  Resolves the shared data wires itself from the host enables and the flash model drive.
*/
`timescale 1ns/1ps
module tb_qfc_host;
  logic i_core_clk = 0, i_rst_n = 0, i_cmd_valid = 0, i_wr_valid = 0, i_qpi_resume = 0;
  qfc_pkg::qfc_cmd_t i_cmd = '0;
  logic [7:0] i_wr_data = '0, o_rd_data, o_read_param;
  logic o_cmd_ready, o_cmd_err, o_wr_ready, o_rd_valid, o_busy, o_wpl, o_vol_armed;
  logic o_deep_pd, o_suspended, o_qpi_active, o_cs_n, o_sclk, m_oe, err_seen, s;
  logic [3:0] o_io_out, o_io_oe, m_io, i_io_in;
  logic [7:0] rq[$], wq[$];
  int num_errors = 0, compares = 0;
  // Floating lines show the inverse of the flash model's last driven nibble
  assign i_io_in = (o_io_oe & o_io_out) | (~o_io_oe & (m_oe ? m_io : ~m_io));
  initial forever #2.5 i_core_clk = ~i_core_clk;
  qfc_host i_qfc_host (.i_core_clk, .i_rst_n, .i_cmd_valid, .i_cmd, .o_cmd_ready, .o_cmd_err,
    .i_wr_valid, .i_wr_data, .o_wr_ready, .o_rd_valid, .o_rd_data, .o_busy, .i_qpi_resume,
    .o_wpl, .o_vol_armed, .o_deep_pd, .o_suspended, .o_qpi_active, .o_read_param, .o_cs_n,
    .o_sclk, .i_io_in, .o_io_out, .o_io_oe);
  qfc_flash_model i_qfc_flash_model (.i_cs_n(o_cs_n), .i_sclk(o_sclk), .i_io(i_io_in),
    .o_io(m_io), .o_oe(m_oe));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results;
    $display("Compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One command frame; collects read bytes, feeds write bytes, waits for idle
  task automatic xfer(input logic [7:0] op, input logic [23:0] ad, input logic [15:0] n);
    int k;
    rq.delete();
    err_seen = 1'b0;
    k = 0;
    @(posedge i_core_clk);
    i_cmd_valid <= 1'b1;
    i_cmd <= {op, ad, n};
    if (wq.size() > 0) begin
      i_wr_valid <= 1'b1;
      i_wr_data <= wq[0];
    end
    @(posedge i_core_clk);
    i_cmd_valid <= 1'b0;
    do begin
      @(posedge i_core_clk);
      k++;
      if (o_cmd_err === 1'b1) err_seen = 1'b1;
      if (o_rd_valid === 1'b1) rq.push_back(o_rd_data);
      if (i_wr_valid === 1'b1 && o_wr_ready === 1'b1) begin
        void'(wq.pop_front());
        if (wq.size() > 0) i_wr_data <= wq[0];
        else i_wr_valid <= 1'b0;
      end
    end while ((o_busy === 1'b1 || k < 2) && k < 4000);
    if (k >= 4000) begin
      num_errors++;
      $display("[ERR] o_busy expected 0 seen 1");
      results();
    end
  endtask
  task automatic t_latch;
    chk("cs_n", 1, o_cs_n);
    chk("rdy", 1, o_cmd_ready);
    chk("qpi", 1, o_qpi_active);
    xfer(8'h06, 0, 1);
    chk("wpl", 1, o_wpl);
    xfer(8'h05, 0, 1);
    chk("sr", 8'h02, rq[0]);
    xfer(8'h04, 0, 1);
    chk("wpl", 0, o_wpl);
    xfer(8'h05, 0, 1);
    chk("sr", 8'h00, rq[0]);
    $display("t_latch finished");
  endtask
  task automatic t_regs;
    logic [7:0] t[3][3] = '{'{8'h01, 8'h05, 8'ha4}, '{8'h31, 8'h35, 8'h5b}, '{8'h11, 8'h15, 8'hc3}};
    foreach (t[j]) begin
      wq = '{t[j][2]};
      xfer(t[j][0], 0, 1);
      xfer(t[j][1], 0, 1);
      chk("reg", t[j][2], rq[0]);
    end
    xfer(8'h50, 0, 1);
    chk("vol", 1, o_vol_armed);
    wq = '{8'h25};
    xfer(8'hc0, 0, 1);
    chk("rparam", 8'h25, o_read_param);
    chk("vol", 0, o_vol_armed);
    $display("t_regs finished");
  endtask
  task automatic t_read;
    logic [7:0] r[3] = '{8'h0b, 8'h0c, 8'heb};
    foreach (r[j]) begin
      xfer(r[j], 24'h00_0120, 4);
      chk("nrd", 4, rq.size());
      foreach (rq[i]) chk("rd", 8'h20 + i, rq[i]);
      chk("nib", 18, i_qfc_flash_model.fr_nib);
    end
    xfer(8'h9f, 0, 5);
    chk("id", 32'h035a_c317, {8'(rq.size()), rq[0], rq[1], rq[2]});
    xfer(8'h90, 24'h00_0000, 4);
    chk("mid", 32'h5a17_5a17, {rq[0], rq[1], rq[2], rq[3]});
    $display("t_read finished");
  endtask
  task automatic t_bare;
    logic [7:0] b[14] = '{8'h7e, 8'h98, 8'h36, 8'h39, 8'h81, 8'h20, 8'h52,
      8'hd8, 8'h60, 8'hc7, 8'h75, 8'h7a, 8'hb0, 8'h30};
    s = 1'b0;
    foreach (b[j]) begin
      xfer(b[j], 24'h01_2340, 1);
      s = (b[j] inside {8'h75, 8'hb0}) ? 1'b1 : (b[j] inside {8'h7a, 8'h30}) ? 1'b0 : s;
      chk("op", {1'b0, b[j]}, {err_seen, i_qfc_flash_model.op});
      chk("susp", s, o_suspended);
      if (b[j] inside {8'h36, 8'h39, 8'h81, 8'h20, 8'h52, 8'hd8}) begin
        chk("adr", 24'h01_2340, i_qfc_flash_model.fr_sh[23:0]);
      end else begin
        chk("nib", 2, i_qfc_flash_model.fr_nib);
      end
    end
    xfer(8'h36, 24'h01_0000, 1);
    xfer(8'h3c, 24'h01_0000, 1);
    chk("lock", 8'h01, rq[0]);
    xfer(8'h98, 0, 1);
    xfer(8'h3d, 24'h01_0000, 1);
    chk("lock", 8'h00, rq[0]);
    wq = '{8'h3c, 8'h96};
    xfer(8'h02, 24'h00_0200, 2);
    chk("prg", 16'h3c96, i_qfc_flash_model.fr_sh[15:0]);
    chk("pnib", 12, i_qfc_flash_model.fr_nib);
    $display("t_bare finished");
  endtask
  task automatic t_modes;
    xfer(8'hb9, 0, 1);
    chk("dpd", 1, o_deep_pd);
    xfer(8'h05, 0, 1);
    chk("err", 1, err_seen);
    xfer(8'hab, 0, 1);
    chk("sig", 9'h017, {o_deep_pd, rq[0]});
    xfer(8'h06, 0, 1);
    xfer(8'h99, 0, 1);
    chk("err", 1, err_seen);
    xfer(8'h66, 0, 1);
    xfer(8'h99, 0, 1);
    chk("rst", 2'b00, {err_seen, o_wpl});
    xfer(8'hff, 0, 1);
    chk("qpi", 0, o_qpi_active);
    xfer(8'h06, 0, 1);
    chk("err", 1, err_seen);
    i_qpi_resume <= 1'b1;
    @(posedge i_core_clk);
    i_qpi_resume <= 1'b0;
    @(posedge i_core_clk);
    chk("qpi", 1, o_qpi_active);
    $display("t_modes finished");
  endtask
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    @(posedge i_core_clk);
    t_latch();
    t_regs();
    t_read();
    t_bare();
    t_modes();
    results();
  end
endmodule // tb_qfc_host
